// ---- pkg/adcf_pkg.sv ----
// constants and types of the converter control block
package adcf_pkg;

	// ----------------------------------------
	// register map (word indices on the port)
	// ----------------------------------------
	localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;
	localparam logic [1:0] ADDR_RESULT_HIGH = 2'h1;
	localparam logic [1:0] ADDR_RESULT_LOW = 2'h2;
	localparam logic [1:0] ADDR_CLOCK = 2'h3;

	// ----------------------------------------
	// status/control field layout and result width
	// ----------------------------------------
	localparam int CS_DONE_BIT = 7;
	localparam int CS_IRQEN_BIT = 6;
	localparam int CS_CONT_BIT = 5;
	localparam int CH_W = 5;
	localparam int RES_W = 10;

	// ----------------------------------------
	// clock register field layout
	// ----------------------------------------
	localparam int CK_FMT_LO = 2;
	localparam int CK_DIV_LO = 5;
	localparam int CK_SRC_BIT = 4;

	// ----------------------------------------
	// channel codes
	// ----------------------------------------
	localparam logic [4:0] CH_LAST_EXT = 5'h17;
	localparam logic [4:0] CH_REF_HIGH = 5'h1D;
	localparam logic [4:0] CH_REF_LOW = 5'h1E;
	localparam logic [4:0] CH_POWER_OFF = 5'h1F;

	// ----------------------------------------
	// reset values and reference codes
	// ----------------------------------------
	localparam logic [7:0] CS_RESET = 8'h1F;
	localparam logic [7:0] CK_RESET = 8'h04;
	localparam logic [9:0] REF_HIGH_CODE = 10'h3FF;
	localparam logic [9:0] REF_LOW_CODE = 10'h000;

	// ----------------------------------------
	// conversion timing in converter clocks
	// ----------------------------------------
	localparam int CONV_CYCLES = 16;

	typedef enum logic [1:0] {
		FMT_TRUNC = 2'h0,
		FMT_RIGHT = 2'h1,
		FMT_LEFT = 2'h2,
		FMT_LEFT_SIGNED = 2'h3
	} adcf_fmt_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} adcf_bus_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} adcf_result_t;

endpackage

// ---- hdl/adcf_format.sv ----
// result formatting into high and low register images
`timescale 1ns/1ps
module adcf_format
	import adcf_pkg::*;
(
	input wire logic [RES_W-1:0] raw,
	input wire adcf_fmt_t fmt,
	output adcf_result_t img
);
	always_comb begin
		img = '0;
		unique case (fmt)
			FMT_TRUNC: begin
				img.low = raw[9:2]; // R06
			end
			FMT_RIGHT: begin
				img.high = {6'h00, raw[9:8]}; // R04
				img.low = raw[7:0];
			end
			FMT_LEFT: begin
				img.high = raw[9:2]; // R02
				img.low = {raw[1:0], 6'h00};
			end
			FMT_LEFT_SIGNED: begin
				img.high = {~raw[9], raw[8:2]}; // R05
				img.low = {raw[1:0], 6'h00};
			end
		endcase
	end
endmodule

// ---- hdl/adcf_ctrl.sv ----
// control, sequencing and result registers of the converter
`timescale 1ns/1ps

// What this block does
// R01: four result formats chosen by two format bits of the clock register
// R02: left format puts top eight bits high, lowest two low
// R03: outside truncation, high read needs low read or results are blocked
// R04: right format puts top two bits high, lower eight low
// R05: signed left format equals left format with bit 9 inverted
// R06: truncation puts top eight bits low, drops lowest two
// R07: truncation format has no high/low read interlock
// R08: interrupt enabled raises request at every conversion end
// R09: with interrupt enabled done flag never sets and reads zero
// R10: interrupt disabled sets done flag until result read; reset clears
// R11: request drops on result read or control write; reset clears enable
// R12: continuous bit repeats conversions; else one per control write
// R13: five-bit channel field, 32 codes, 24 external inputs
// R14: channel code all ones powers the converter off
// R15: channel codes route high and low references into converter
// R16: software discards first conversion after power-off code
// R17: wait mode keeps converting; enabled interrupt wakes processor
// R18: stop mode aborts conversion, goes idle, resumes after exit
// R19: software writes zero into done flag position
// R20: control write starts conversion of 16 to 17 converter clocks
// R21: continuous mode overwrites result unless the high/low read interlock holds it
// R22: format codes 00 trunc, 01 right, 10 left, 11 signed; reset right
// R23: outside truncation, high read latches low register until low read
module adcf_ctrl
	import adcf_pkg::*;
#(
	parameter int CONV_CLKS = CONV_CYCLES,
	parameter int DIV_MAX_LOG = 4
)(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	input wire logic stop_mode,
	input wire logic [RES_W-1:0] sample_data,
	output logic [CH_W-1:0] channel_select,
	output logic sample_start,
	output logic conv_power_off,
	output logic conv_irq,
	output logic wake_req
);
	initial begin
		if (CONV_CLKS < 2 || CONV_CLKS > 255 || DIV_MAX_LOG != 4) begin
			$error("adcf_ctrl: unsupported parameter value");
		end
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	adcf_bus_t bus;
	assign bus = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
	logic wr_cs, wr_ck, rd_hi, rd_lo;
	assign wr_cs = bus.wr && bus.addr == ADDR_CTRL_STATUS;
	assign wr_ck = bus.wr && bus.addr == ADDR_CLOCK;
	assign rd_hi = bus.rd && bus.addr == ADDR_RESULT_HIGH;
	assign rd_lo = bus.rd && bus.addr == ADDR_RESULT_LOW;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DONE = 2'b11
	} adcf_state_t;

	adcf_state_t st_q, st_d;
	logic irq_en_q, irq_en_d, cont_q, cont_d;
	logic [CH_W-1:0] ch_q, ch_d;
	logic [7:0] ck_q, ck_d;
	logic done_q, done_d, irq_q, irq_d;
	logic lock_q, lock_d;
	adcf_result_t res_q, res_d;
	logic [7:0] low_hold_q, low_hold_d;
	logic [7:0] cnt_q, cnt_d;
	logic [3:0] pre_q, pre_d;
	logic [7:0] rdata_d;
	logic start_q, start_d;
	logic resume_q, resume_d;
	adcf_result_t img;
	logic [RES_W-1:0] raw;
	adcf_fmt_t fmt;
	logic tick, is_trunc, fin;
	logic [3:0] div_lim;

	assign fmt = adcf_fmt_t'(ck_q[CK_FMT_LO +: 2]); // R01
	assign is_trunc = fmt == FMT_TRUNC;

	// reference codes replace the sampled input
	always_comb begin
		unique case (ch_q)
			CH_REF_HIGH: raw = REF_HIGH_CODE; // R15
			CH_REF_LOW: raw = REF_LOW_CODE; // R15
			default: raw = sample_data; // R13
		endcase
	end

	adcf_format u_fmt (
		.raw(raw),
		.fmt(fmt),
		.img(img)
	);

	// converter clock prescaler
	always_comb begin
		unique case (ck_q[CK_DIV_LO +: 3])
			3'h0: div_lim = 4'h0;
			3'h1: div_lim = 4'h1;
			3'h2: div_lim = 4'h3;
			3'h3: div_lim = 4'h7;
			default: div_lim = 4'hF;
		endcase
	end
	assign tick = pre_q == div_lim;
	assign fin = st_q == ST_CONV && tick && cnt_q == 8'(CONV_CLKS - 1);

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		irq_en_d = irq_en_q;
		cont_d = cont_q;
		ch_d = ch_q;
		ck_d = ck_q;
		done_d = done_q;
		irq_d = irq_q;
		lock_d = lock_q;
		res_d = res_q;
		low_hold_d = low_hold_q;
		cnt_d = cnt_q;
		start_d = 1'b0;
		resume_d = resume_q;
		pre_d = tick ? 4'h0 : pre_q + 4'h1;
		if (wr_ck) begin
			ck_d = bus.wdata; // R22
		end
		if (rd_hi || rd_lo) begin
			done_d = 1'b0; // R10
			irq_d = 1'b0; // R11
		end
		if (rd_hi && !is_trunc) begin
			lock_d = 1'b1; // R23
			low_hold_d = res_q.low;
		end
		if (rd_lo) begin
			lock_d = 1'b0; // R03
		end
		unique case (st_q)
			ST_IDLE: begin
			end
			ST_CONV: begin
				if (tick) begin
					cnt_d = cnt_q + 8'h01; // R20
				end
				if (fin) begin
					st_d = ST_DONE;
				end
			end
			ST_DONE: begin
				// store unless the interlock holds the result
				if (is_trunc || !lock_q) begin
					res_d = img; // R07 R21
				end
				if (irq_en_q) begin
					irq_d = 1'b1; // R08 R17
				end else begin
					done_d = 1'b1; // R09 R10
				end
				cnt_d = 8'h00;
				st_d = cont_q ? ST_CONV : ST_IDLE; // R12
				start_d = cont_q;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
		if (wr_cs) begin
			irq_en_d = bus.wdata[CS_IRQEN_BIT];
			cont_d = bus.wdata[CS_CONT_BIT];
			ch_d = bus.wdata[CH_W-1:0];
			irq_d = 1'b0; // R11
			cnt_d = 8'h00;
			if (bus.wdata[CH_W-1:0] != CH_POWER_OFF) begin
				st_d = ST_CONV; // R20
				start_d = 1'b1;
			end else begin
				st_d = ST_IDLE; // R14
			end
		end
		if (irq_en_d) begin
			done_d = 1'b0; // R09
		end
		if (stop_mode) begin
			// remember an aborted or requested conversion for the exit
			resume_d = resume_q || st_d != ST_IDLE;
			st_d = ST_IDLE; // R18
			start_d = 1'b0;
			cnt_d = 8'h00;
		end else if (resume_q) begin
			resume_d = 1'b0;
			if (ch_d != CH_POWER_OFF) begin
				st_d = ST_CONV; // R18
				start_d = 1'b1;
				cnt_d = 8'h00;
			end
		end
	end

	// read data, one cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (bus.rd) begin
			unique case (bus.addr)
				ADDR_CTRL_STATUS: begin
					rdata_d = {3'h0, ch_q};
					rdata_d[CS_DONE_BIT] = done_q && !irq_en_q; // R09
					rdata_d[CS_IRQEN_BIT] = irq_en_q;
					rdata_d[CS_CONT_BIT] = cont_q;
				end
				ADDR_RESULT_HIGH: rdata_d = res_q.high;
				ADDR_RESULT_LOW: rdata_d = lock_q ? low_hold_q : res_q.low; // R23
				ADDR_CLOCK: rdata_d = ck_q;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			irq_en_q <= CS_RESET[CS_IRQEN_BIT]; // R11
			cont_q <= CS_RESET[CS_CONT_BIT]; // R12
			ch_q <= CS_RESET[CH_W-1:0];
			ck_q <= CK_RESET; // R22
			done_q <= 1'b0; // R10
			irq_q <= 1'b0;
			lock_q <= 1'b0;
			res_q <= '0;
			low_hold_q <= 8'h00;
			cnt_q <= 8'h00;
			pre_q <= 4'h0;
			rdata <= 8'h00;
			start_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			st_q <= st_d;
			irq_en_q <= irq_en_d;
			cont_q <= cont_d;
			ch_q <= ch_d;
			ck_q <= ck_d;
			done_q <= done_d;
			irq_q <= irq_d;
			lock_q <= lock_d;
			res_q <= res_d;
			low_hold_q <= low_hold_d;
			cnt_q <= cnt_d;
			pre_q <= pre_d;
			rdata <= rdata_d;
			start_q <= start_d;
			resume_q <= resume_d;
		end
	end

	// ----------------------------------------
	// outputs to the analog side and the cpu
	// ----------------------------------------
	logic pwr_off_q, wake_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pwr_off_q <= 1'b1;
			wake_q <= 1'b0;
		end else begin
			pwr_off_q <= ch_d == CH_POWER_OFF || stop_mode; // R14 R18
			wake_q <= irq_d; // R17
		end
	end
	assign channel_select = ch_q;
	assign sample_start = start_q;
	assign conv_power_off = pwr_off_q;
	assign conv_irq = irq_q;
	assign wake_req = wake_q;
endmodule

// ---- tb/adcf_ctrl_monitor.sv ----
// bound assertion checker for the converter control block
`timescale 1ns/1ps
module adcf_mon
	import adcf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rdata,
	input wire logic stop_mode,
	input wire logic [CH_W-1:0] channel_select,
	input wire logic sample_start,
	input wire logic conv_power_off,
	input wire logic conv_irq
);
	// ------------
	// assertions
	// ------------
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	wire logic wc = wr_stb && addr == ADDR_CTRL_STATUS;
	wire logic rr = rd_stb && (addr == ADDR_RESULT_HIGH || addr == ADDR_RESULT_LOW);
	chk_ch_write: assert property (wc |=> channel_select == $past(wdata[4:0]))
		else $error("channel not taken");
	chk_stop_off: assert property (stop_mode [*3] |-> conv_power_off)
		else $error("stop left converter on");
	chk_stop_idle: assert property (stop_mode [*2] |-> !sample_start)
		else $error("start during stop");
	chk_start_wr: assert property (wc && !stop_mode && !(&wdata[4:0]) |=> sample_start)
		else $error("write did not start");
	chk_irq_wr_clr: assert property (wc |=> !conv_irq)
		else $error("irq kept after write");
	chk_irq_rd_clr: assert property (rr |=> !conv_irq)
		else $error("irq kept after read");
	chk_irq_hold: assert property (conv_irq && !wr_stb && !rd_stb |=> conv_irq)
		else $error("irq dropped early");
	chk_done_zero: assert property (conv_irq && rd_stb && !addr |=> !rdata[CS_DONE_BIT])
		else $error("done set with irq");
	cov_irq: cover property ($rose(conv_irq));
	cov_stop: cover property (stop_mode ##1 !stop_mode);
	cov_off: cover property ($rose(conv_power_off));
endmodule
bind adcf_ctrl adcf_mon u_mon (.clk_sys, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
	.stop_mode, .channel_select, .sample_start, .conv_power_off, .conv_irq);

// ---- tb/adcf_ctrl_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcf_ctrl_tb
	import adcf_pkg::*;
;
	logic clk_sys = 1'h0;
	logic nrst = 1'h0;
	logic wr_stb = 1'h0;
	logic rd_stb = 1'h0;
	logic stop_mode = 1'h0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic [9:0] sample_data = 10'h2D6;
	logic [7:0] rdata, got;
	logic [15:0] e;
	logic [4:0] channel_select;
	logic sample_start, conv_power_off, conv_irq, wake_req;
	int failures = 0;
	int num_checks = 0;
	int starts = 0;

	adcf_ctrl #(.CONV_CLKS(2)) dut (.clk_sys, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.stop_mode, .sample_data, .channel_select, .sample_start, .conv_power_off,
		.conv_irq, .wake_req);

	initial forever #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (sample_start === 1'h1) starts++;

	// ------------
	// helpers
	// ------------
	function automatic logic [15:0] img(input logic [1:0] f, input logic [9:0] r);
		case (f)
			2'h0: return {8'h00, r[9:2]};
			2'h1: return {6'h00, r};
			2'h2: return {r, 6'h00};
			default: return {~r[9], r[8:0], 6'h00};
		endcase
	endfunction

	task chk(input logic [7:0] s, input logic [7:0] x);
		num_checks++;
		if (s !== x) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	task give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task wr(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'h1;
		@(posedge clk_sys);
		wr_stb <= 1'h0;
		@(posedge clk_sys);
	endtask

	task rd(input logic [1:0] a);
		addr <= a;
		rd_stb <= 1'h1;
		@(posedge clk_sys);
		rd_stb <= 1'h0;
		@(negedge clk_sys);
		got = rdata;
		@(posedge clk_sys);
	endtask

	task rc(input logic [1:0] a, input logic [7:0] x);
		rd(a);
		chk(got, x);
	endtask

	task conv(input logic [7:0] c);
		wr(ADDR_CTRL_STATUS, c);
		for (int i = 0; i < 99; i++) begin
			@(negedge clk_sys);
			if (conv_irq === 1'h1) begin
				@(posedge clk_sys);
				return;
			end
		end
		failures++;
		give_verdict;
	endtask

	task poll;
		for (int i = 0; i < 30; i++) begin
			rd(ADDR_CTRL_STATUS);
			if (got[CS_DONE_BIT] === 1'h1)
				return;
		end
		failures++;
		give_verdict;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'h1;
		@(posedge clk_sys);
		rc(ADDR_CTRL_STATUS, CS_RESET);
		rc(ADDR_CLOCK, CK_RESET);
		conv(8'h43);
		for (int f = 0; f < 4; f++) begin
			wr(ADDR_CLOCK, 8'(f << CK_FMT_LO));
			conv(8'h43);
			rc(ADDR_CTRL_STATUS, 8'h43);
			e = img(2'(f), sample_data);
			rc(ADDR_RESULT_HIGH, e[15:8]);
			rc(ADDR_RESULT_LOW, e[7:0]);
		end
		wr(ADDR_CLOCK, CK_RESET);
		conv(8'h40 | CH_REF_HIGH);
		rc(ADDR_RESULT_LOW, 8'hFF);
		conv(8'h40 | CH_REF_LOW);
		rc(ADDR_RESULT_LOW, 8'h00);
		conv(8'h43);
		rc(ADDR_RESULT_HIGH, 8'h02);
		sample_data <= 10'h129;
		conv(8'h43);
		rc(ADDR_RESULT_LOW, 8'hD6);
		conv(8'h43);
		rc(ADDR_RESULT_HIGH, 8'h01);
		rc(ADDR_RESULT_LOW, 8'h29);
		wr(ADDR_CLOCK, 8'h00);
		conv(8'h43);
		rc(ADDR_RESULT_HIGH, 8'h00);
		sample_data <= 10'h2D6;
		conv(8'h43);
		rc(ADDR_RESULT_LOW, 8'hB5);
		wr(ADDR_CLOCK, CK_RESET);
		wr(ADDR_CTRL_STATUS, 8'h03);
		poll;
		chk(got, 8'h83);
		rc(ADDR_RESULT_LOW, 8'hD6);
		rc(ADDR_CTRL_STATUS, 8'h03);
		starts = 0;
		repeat (30) @(posedge clk_sys);
		chk(8'(starts), 8'h00);
		wr(ADDR_CTRL_STATUS, 8'h23);
		starts = 0;
		repeat (20) @(posedge clk_sys);
		sample_data <= 10'h129;
		repeat (20) @(posedge clk_sys);
		chk(8'(starts > 3), 8'h01);
		rc(ADDR_RESULT_HIGH, 8'h01);
		rc(ADDR_RESULT_LOW, 8'h29);
		stop_mode <= 1'h1;
		repeat (3) @(posedge clk_sys);
		starts = 0;
		repeat (20) @(posedge clk_sys);
		chk({conv_power_off, 7'(starts)}, 8'h80);
		stop_mode <= 1'h0;
		repeat (20) @(posedge clk_sys);
		chk(8'(starts > 0), 8'h01);
		wr(ADDR_CLOCK, 8'h84);
		conv(8'h43);
		rc(ADDR_RESULT_LOW, 8'h29);
		conv(8'h43);
		repeat (2) @(posedge clk_sys);
		chk({7'h00, wake_req}, 8'h01);
		wr(ADDR_CTRL_STATUS, CS_RESET);
		@(negedge clk_sys);
		chk({conv_power_off, 6'h00, conv_irq}, 8'h80);
		give_verdict;
	end
endmodule
